// ==== rtl/qpt_pkg.sv ====
// Constants, register map and carrier types of the four-channel preload timer.
// What this block does
// RULE1: Timers 0-2 tick at system clock/4; timer 3 at clock/4 or strapped 32 kHz.
// RULE2: With the 32 kHz source, timer 3 keeps counting while the device halts.
// RULE3: Each timer's source passes a prescaler set by control bits 2..0.
// RULE4: Counter adds one per prescaled pulse; passing FFH raises overflow.
// RULE5: On overflow the counter reloads from preload and keeps counting.
// RULE6: Preload write while stopped is copied into the counter at once.
// RULE7: Preload write while running only changes preload; counter takes it on overflow.
// RULE8: Reading a count blocks that timer's input tick; lost counts stay lost.
// RULE9: Software writes mode bits 7..6 as binary 10 for proper operation.
// RULE10: Control bit 4 set lets the timer count; cleared stops it.
// RULE11: Software loads preload before starting; zero gives the full 256 counts.
// RULE12: An overflow interrupts only while that timer's enable bit is set.
// RULE13: Timer 0..3 overflows vector to 08H, 0CH, 10H and 14H.
// RULE14: Overflow sets a sticky flag; cleared on interrupt entry or by software.
// RULE15: Prescaler divides by two to the rate field; overflow event is one cycle.
package qpt_pkg;

  localparam int unsigned NTMR = 4;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_COUNT0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL0  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MASK   = 4'h9;

  // Field positions and values of a timer control register.
  localparam int unsigned CTRL_RATE_LSB = 0;
  localparam int unsigned CTRL_RUN_BIT  = 4;
  localparam int unsigned CTRL_MODE_LSB = 6;
  localparam logic [1:0]  MODE_TIMER    = 2'h2;

  // Reset values.
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST   = 4'h0;

  // Timing.
  localparam int unsigned CLK_HZ       = 50000000;
  localparam int unsigned SYS_DIV      = 4;
  localparam logic [1:0]  SYS_DIV_LAST = 2'(SYS_DIV - 1);
  localparam logic [7:0]  COUNT_MAX    = 8'hff;

  // Interrupt vectors.
  localparam logic [7:0] VEC_BASE = 8'h08;
  localparam logic [7:0] VEC_STEP = 8'h04;

  typedef struct packed {
    logic [1:0] mode;
    logic       rsv5;
    logic       run;
    logic       rsv3;
    logic [2:0] rate;
  } qpt_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } qpt_bus_t;

endpackage : qpt_pkg

// ==== rtl/qpt_timer.sv ====
// Four 8-bit preload timers with prescalers, register port and interrupt flags.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none

module qpt_timer (
  input  wire logic             core_clk_i,    // System clock, 50 MHz.
  input  wire logic             rst_b_i,       // Asynchronous reset, active low.
  input  wire qpt_pkg::qpt_bus_t bus_i,        // Register port request.
  output logic [7:0]            rd_data_o,     // Read data, cycle after read strobe.
  input  wire logic             halt_i,        // Device is in halt power-down.
  input  wire logic             rtc_clk_i,     // 32 kHz crystal clock pin.
  input  wire logic             cfg_rtc_sel_i, // Strap: timer 3 uses the 32 kHz source.
  input  wire logic             irq_ack_i,     // Interrupt entry acknowledge pulse.
  output logic                  irq_o,         // Interrupt request level.
  output logic [7:0]            irq_vec_o,     // Vector of lowest-numbered pending timer.
  output logic [3:0]            ovf_o          // Registered overflow pulses.
);
  import qpt_pkg::*;

  function automatic logic [6:0] rate_mask(input logic [2:0] rate);
    return 7'((8'h01 << rate) - 8'h01);
  endfunction : rate_mask

  function automatic logic is_addr(input qpt_bus_t b, input logic [3:0] a);
    return b.addr == a;
  endfunction : is_addr

  logic [1:0]      div_r;
  logic            sys_tick;
  logic            rtc_meta_r;
  logic            rtc_sync_r;
  logic            rtc_prev_r;
  logic            rtc_tick;
  logic            rtc_sel_r;
  logic            strap_done_r;
  qpt_ctrl_t       ctrl_r    [NTMR];
  logic [7:0]      count_r   [NTMR];
  logic [7:0]      preload_r [NTMR];
  logic [6:0]      pre_r     [NTMR];
  logic [NTMR-1:0] src_tick;
  logic [NTMR-1:0] rd_blk;
  logic [NTMR-1:0] cnt_wr;
  logic [NTMR-1:0] enabled;
  logic [NTMR-1:0] gated;
  logic [NTMR-1:0] pre_tick;
  logic [NTMR-1:0] ovf_evt;
  logic [3:0]      status_r;
  logic [3:0]      mask_r;
  logic [3:0]      pend;
  logic [1:0]      first_idx;
  logic [1:0]      vec_idx_r;
  logic            vec_valid_r;
  logic [7:0]      rd_data_r;
  logic [3:0]      ovf_r;

  // Divide the system clock by four; the divider stops while halted.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r <= 2'h0;
    end else if (!halt_i) begin
      div_r <= div_r + 2'h1;
    end
  end

  assign sys_tick = !halt_i && (div_r == SYS_DIV_LAST); // RULE1

  // The crystal clock is sampled as a level and its rising edge becomes a tick.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rtc_meta_r <= 1'b0;
      rtc_sync_r <= 1'b0;
      rtc_prev_r <= 1'b0;
    end else begin
      rtc_meta_r <= rtc_clk_i;
      rtc_sync_r <= rtc_meta_r;
      rtc_prev_r <= rtc_sync_r;
    end
  end

  assign rtc_tick = rtc_sync_r && !rtc_prev_r; // RULE2

  // The source option is a strap, caught once after reset release.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rtc_sel_r    <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      rtc_sel_r    <= cfg_rtc_sel_i;
      strap_done_r <= 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < NTMR; i++) begin
      src_tick[i] = (i == NTMR - 1 && rtc_sel_r) ? rtc_tick : sys_tick; // RULE1
      rd_blk[i]   = bus_i.rd && is_addr(bus_i, ADDR_COUNT0 + 4'(i)); // RULE8
      cnt_wr[i]   = bus_i.wr && is_addr(bus_i, ADDR_COUNT0 + 4'(i));
      enabled[i]  = ctrl_r[i].run && (ctrl_r[i].mode == MODE_TIMER); // RULE10
      gated[i]    = src_tick[i] && enabled[i] && !rd_blk[i]; // RULE8
      pre_tick[i] = gated[i] &&
                    ((pre_r[i] & rate_mask(ctrl_r[i].rate)) == rate_mask(ctrl_r[i].rate)); // RULE3
      ovf_evt[i]  = pre_tick[i] && (count_r[i] == COUNT_MAX); // RULE4
    end
  end

  // Control registers.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NTMR; i++) begin
        ctrl_r[i] <= qpt_ctrl_t'(CTRL_RST);
      end
    end else if (bus_i.wr && bus_i.addr[3:2] == ADDR_CTRL0[3:2]) begin
      ctrl_r[bus_i.addr[1:0]] <= qpt_ctrl_t'(bus_i.wdata);
    end
  end

  // Prescalers restart from zero whenever their timer is stopped.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NTMR; i++) begin
        pre_r[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < NTMR; i++) begin
        if (!enabled[i]) begin
          pre_r[i] <= 7'h00;
        end else if (gated[i]) begin
          pre_r[i] <= pre_r[i] + 7'h01; // RULE15
        end
      end
    end
  end

  // Preload registers take every write to the count address.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NTMR; i++) begin
        preload_r[i] <= COUNT_RST;
      end
    end else begin
      for (int i = 0; i < NTMR; i++) begin
        if (cnt_wr[i]) begin
          preload_r[i] <= bus_i.wdata; // RULE7
        end
      end
    end
  end

  // Counters; a reload on overflow uses the preload held before any same-cycle write.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NTMR; i++) begin
        count_r[i] <= COUNT_RST;
      end
    end else begin
      for (int i = 0; i < NTMR; i++) begin
        if (cnt_wr[i] && !ctrl_r[i].run) begin
          count_r[i] <= bus_i.wdata; // RULE6
        end else if (ovf_evt[i]) begin
          count_r[i] <= preload_r[i]; // RULE5
        end else if (pre_tick[i]) begin
          count_r[i] <= count_r[i] + 8'h01; // RULE4
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovf_r <= 4'h0;
    end else begin
      ovf_r <= ovf_evt; // RULE15
    end
  end

  assign ovf_o = ovf_r;

  // Sticky flags: an overflow in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r <= STATUS_RST;
    end else begin
      for (int i = 0; i < NTMR; i++) begin
        if (ovf_evt[i]) begin
          status_r[i] <= 1'b1; // RULE14
        end else if ((bus_i.wr && is_addr(bus_i, ADDR_STATUS) && bus_i.wdata[i]) ||
                     (irq_ack_i && vec_valid_r && vec_idx_r == 2'(i))) begin
          status_r[i] <= 1'b0; // RULE14
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r <= MASK_RST;
    end else if (bus_i.wr && is_addr(bus_i, ADDR_MASK)) begin
      mask_r <= bus_i.wdata[3:0];
    end
  end

  assign pend  = status_r & mask_r; // RULE12
  assign irq_o = |pend; // RULE12

  // Lowest timer number has the highest priority.
  always_comb begin
    first_idx = 2'h0;
    for (int i = NTMR - 1; i >= 0; i--) begin
      if (pend[i]) begin
        first_idx = 2'(i);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_idx_r   <= 2'h0;
      vec_valid_r <= 1'b0;
      irq_vec_o   <= VEC_BASE;
    end else begin
      vec_idx_r   <= first_idx;
      vec_valid_r <= |pend;
      irq_vec_o   <= VEC_BASE + (VEC_STEP * {6'h00, first_idx}); // RULE13
    end
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_r <= 8'h00;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        4'h0, 4'h1, 4'h2, 4'h3: rd_data_r <= count_r[bus_i.addr[1:0]];
        4'h4, 4'h5, 4'h6, 4'h7: rd_data_r <= ctrl_r[bus_i.addr[1:0]];
        ADDR_STATUS:            rd_data_r <= {4'h0, status_r};
        ADDR_MASK:              rd_data_r <= {4'h0, mask_r};
        default:                rd_data_r <= 8'h00;
      endcase
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign rd_data_o = rd_data_r;

  sequence s_sys_gap;
    !sys_tick [*3];
  endsequence

  a_sys_tick_rate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE1
    sys_tick |=> s_sys_gap)
    else $error("System tick spacing is not four cycles.");

  a_halt_stops_sys: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE2
    halt_i && !rtc_sel_r |-> !src_tick[0] && !src_tick[NTMR-1])
    else $error("Divided clock ticks during halt.");

  a_rtc_in_halt: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE2
    rtc_sel_r && halt_i && rtc_tick && enabled[NTMR-1] && !rd_blk[NTMR-1] |=>
      pre_r[NTMR-1] != $past(pre_r[NTMR-1]))
    else $error("Slow-clock timer stopped during halt.");

  a_strap_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE1
    strap_done_r |=> rtc_sel_r == $past(rtc_sel_r))
    else $error("Timer 3 source changed after the strap was taken.");

  // The same checks are repeated for every timer.
  for (genvar g = 0; g < NTMR; g++) begin : g_chk
    a_count_step: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE4
      pre_tick[g] && count_r[g] != COUNT_MAX && !cnt_wr[g] |=>
        count_r[g] == $past(count_r[g]) + 8'h01)
      else $error("Counter did not step by one.");

    a_ovf_reload: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE5
      ovf_evt[g] && ctrl_r[g].run |=> count_r[g] == $past(preload_r[g]) && status_r[g])
      else $error("Overflow did not reload and flag.");

    a_stop_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE6
      cnt_wr[g] && !ctrl_r[g].run |=> count_r[g] == $past(bus_i.wdata))
      else $error("Stopped preload write missed the counter.");

    a_run_keep: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE7
      cnt_wr[g] && ctrl_r[g].run && !pre_tick[g] |=>
        count_r[g] == $past(count_r[g]) && preload_r[g] == $past(bus_i.wdata))
      else $error("Running preload write disturbed the counter.");

    a_read_block: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE8
      rd_blk[g] && enabled[g] |=>
        count_r[g] == $past(count_r[g]) && pre_r[g] == $past(pre_r[g]))
      else $error("Timer advanced during its read.");

    a_read_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE8
      rd_blk[g] |=> rd_data_o == $past(count_r[g]))
      else $error("Count read returned a moving value.");

    a_stop_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE10
      !ctrl_r[g].run && !cnt_wr[g] |=> count_r[g] == $past(count_r[g]))
      else $error("Stopped timer changed its count.");

    a_ovf_single: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE15
      ovf_evt[g] |=> ovf_o[g] && !ovf_evt[g])
      else $error("Overflow event is not a single cycle.");

    a_pre_restart: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE15
      !enabled[g] |=> pre_r[g] == 7'h00)
      else $error("Prescaler did not restart while stopped.");

    a_flag_w1c: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE14
      bus_i.wr && is_addr(bus_i, ADDR_STATUS) && bus_i.wdata[g] && !ovf_evt[g] |=>
        !status_r[g])
      else $error("Write-one did not clear the overflow flag.");

    a_flag_ack: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE14
      irq_ack_i && vec_valid_r && vec_idx_r == 2'(g) && !ovf_evt[g] |=> !status_r[g])
      else $error("Interrupt entry did not clear the overflow flag.");

    a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE14
      status_r[g] && !bus_i.wr && !irq_ack_i |=> status_r[g])
      else $error("Overflow flag dropped without a clear.");
  end

  a_irq_mask: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE12
    ovf_evt[0] && !mask_r[0] && pend == 4'h0 && !bus_i.wr |=> !irq_o)
    else $error("Masked overflow raised the interrupt.");

  a_vec_map: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE13
    pend == 4'h8 |=> irq_vec_o == 8'h14)
    else $error("Timer 3 vector is wrong.");

  // The lowest pending timer number decides the vector.
  a_vec_t0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE13
    pend[0] |=> irq_vec_o == 8'h08)
    else $error("Timer 0 vector is wrong.");

  a_vec_t1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE13
    pend[1:0] == 2'h2 |=> irq_vec_o == 8'h0c)
    else $error("Timer 1 vector is wrong.");

  a_vec_t2: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE13
    pend[2:0] == 3'h4 |=> irq_vec_o == 8'h10)
    else $error("Timer 2 vector is wrong.");

endmodule : qpt_timer

`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the four-channel preload timer.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import qpt_pkg::*;

  logic       core_clk_i    = 1'b0;
  logic       rst_b_i       = 1'b0;
  qpt_bus_t   bus_i         = '0;
  logic       halt_i        = 1'b0;
  logic       rtc_clk_i     = 1'b0;
  logic       cfg_rtc_sel_i = 1'b0;
  logic       irq_ack_i     = 1'b0;
  logic [7:0] rd_data_o;
  logic       irq_o;
  logic [7:0] irq_vec_o;
  logic [3:0] ovf_o;
  int         n_fail        = 0;
  int         check_count   = 0;
  logic [7:0] d;
  logic [7:0] pre;
  int         n;
  int         r;
  int         ti;

  always #10 core_clk_i = ~core_clk_i;
  always #15625 rtc_clk_i = ~rtc_clk_i;

  qpt_timer i_dut (
    .core_clk_i    (core_clk_i),
    .rst_b_i       (rst_b_i),
    .bus_i         (bus_i),
    .rd_data_o     (rd_data_o),
    .halt_i        (halt_i),
    .rtc_clk_i     (rtc_clk_i),
    .cfg_rtc_sel_i (cfg_rtc_sel_i),
    .irq_ack_i     (irq_ack_i),
    .irq_o         (irq_o),
    .irq_vec_o     (irq_vec_o),
    .ovf_o         (ovf_o)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // One register cycle; the read data are captured in the cycle after the strobe.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    bus_i <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge core_clk_i);
    bus_i <= '0;
    #1 d = rd_data_o;
  endtask : bus

  // Returns the cycles from the edge after the previous pulse up to this pulse.
  task automatic wait_ovf(input int i, output int c);
    c = 0;
    do begin
      @(posedge core_clk_i);
      #1 c++;
    end while (ovf_o[i] !== 1'b1 && c < 20000);
    chk(ovf_o[i], 1'b1);
    @(posedge core_clk_i);
    #1 chk(ovf_o[i], 1'b0);
  endtask : wait_ovf

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h5687));
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 11; a++) begin
      bus(1'b0, 4'(a), 8'h00);
      chk(d, 8'h00);
    end
    chk({irq_o, irq_vec_o}, {1'b0, VEC_BASE});
    // A stopped or wrongly moded timer must hold the copied preload.
    for (ti = 0; ti < 4; ti++) begin
      pre = 8'($urandom());
      bus(1'b1, ADDR_COUNT0 + 4'(ti), pre);
      bus(1'b0, ADDR_COUNT0 + 4'(ti), 8'h00);
      chk(d, pre);
      bus(1'b1, ADDR_CTRL0 + 4'(ti), ti[0] ? 8'h10 : 8'h87);
      repeat (100) @(posedge core_clk_i);
      bus(1'b0, ADDR_COUNT0 + 4'(ti), 8'h00);
      chk(d, pre);
    end
    // Every rate is run once; the steady period shows divider, prescaler and reload.
    for (r = 0; r < 8; r++) begin
      ti = r % 4;
      bus(1'b1, ADDR_COUNT0 + 4'(ti), 8'hfc);
      bus(1'b1, ADDR_CTRL0 + 4'(ti), 8'h90 | 8'(r));
      wait_ovf(ti, n);
      wait_ovf(ti, n);
      chk(n + 1, 16 << r);
      bus(1'b1, ADDR_COUNT0 + 4'(ti), 8'hf8);
      bus(1'b0, ADDR_COUNT0 + 4'(ti), 8'h00);
      chk(d >= 8'hfc, 1'b1);
      wait_ovf(ti, n);
      wait_ovf(ti, n);
      chk(n + 1, 32 << r);
      bus(1'b1, ADDR_CTRL0 + 4'(ti), 8'h80);
    end
    // A zero preload gives the full 256-count period.
    bus(1'b1, ADDR_COUNT0 + 4'h2, 8'h00);
    bus(1'b1, ADDR_CTRL0 + 4'h2, 8'h90);
    wait_ovf(2, n);
    wait_ovf(2, n);
    chk(n + 1, 256 * SYS_DIV);
    bus(1'b1, ADDR_CTRL0 + 4'h2, 8'h80);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(d, 8'h0f);
    chk(irq_o, 1'b0);
    bus(1'b1, ADDR_MASK, 8'h04);
    @(posedge core_clk_i);
    #1 chk({irq_o, irq_vec_o}, {1'b1, 8'h10});
    bus(1'b1, ADDR_MASK, 8'h0f);
    bus(1'b1, ADDR_STATUS, 8'h01);
    @(posedge core_clk_i);
    #1 chk(irq_vec_o, VEC_BASE + VEC_STEP);
    @(posedge core_clk_i);
    irq_ack_i <= 1'b1;
    @(posedge core_clk_i);
    irq_ack_i <= 1'b0;
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(d, 8'h0c);
    chk(irq_vec_o, 8'h10);
    bus(1'b1, ADDR_STATUS, 8'h04);
    @(posedge core_clk_i);
    #1 chk({irq_o, irq_vec_o}, {1'b1, 8'h14});
    bus(1'b1, ADDR_STATUS, 8'h0f);
    chk(irq_o, 1'b0);
    // Second reset with timer 3 strapped to the slow source and the device halted.
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    cfg_rtc_sel_i <= 1'b1;
    halt_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (ti = 0; ti < 4; ti += 3) begin
      bus(1'b1, ADDR_COUNT0 + 4'(ti), 8'hfc);
      bus(1'b1, ADDR_CTRL0 + 4'(ti), 8'h90);
    end
    wait_ovf(3, n);
    wait_ovf(3, n);
    chk(n > 6240 && n < 6260, 1'b1);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(d, 8'h08);
    end_sim();
  end

endmodule : tb

`default_nettype wire
